// ---- hw/sram_pkg.sv ----
/*
 * shared constants and carrier types for the pipelined synchronous sram
 * with no bus turnaround. assumes a single 25 MHz core_clk and a bus
 * master on that same clock driving address and control.
 */
package sram_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int LANE_W = 8;
    localparam int LANES = DATA_W / LANE_W;
    localparam int MEM_WORDS = 1 << ADDR_W;
    localparam int BURST_W = 2;
    localparam int WBUF_DEPTH = 8;
    localparam int WR_ENTRY_W = ADDR_W + DATA_W + LANES;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
    localparam logic [1:0] SYNC_RESET = 2'h0;

    typedef enum logic [1:0] {
        ACC_NONE,
        ACC_READ,
        ACC_WRITE
    } acc_t;

    // one access travelling down the two-stage pipeline
    typedef struct packed {
        acc_t op;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] be;
    } stage_t;

    // running burst: what kind, where it started, how far along
    typedef struct packed {
        acc_t kind;
        logic [ADDR_W-1:0] base;
        logic [BURST_W-1:0] cnt;
    } burst_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] be;
    } wr_entry_t;

endpackage

// ---- hw/burst_addr_gen.sv ----
/*
 * low address bits of the current burst beat from start bits and count.
 * assumes start and count are stable flop outputs of the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module burst_addr_gen
    import sram_pkg::*;
(
    input wire logic [BURST_W-1:0] start_low, // low bits loaded at burst start
    input wire logic [BURST_W-1:0] beat_cnt, // beat number within the burst
    input wire logic interleave, // high selects interleaved order
    output logic [BURST_W-1:0] beat_low // low bits of this beat
);
    // interleaved flips bits
    // xor by the beat count gives the flip pattern of every start value
    // linear wraps modulo four
    assign beat_low = interleave ? (start_low ^ beat_cnt)
                                 : (start_low + beat_cnt);
endmodule
`default_nettype wire

// ---- hw/word_fifo.sv ----
/*
 * small fifo with valid/ready on both sides and an oldest-first view of
 * its contents so the owner can look ahead. depth must be a power of two.
 */
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic core_clk, // clock
    input wire logic reset, // synchronous, active high
    input wire logic in_valid, // word offered
    output logic in_ready, // room for a word
    input wire logic [WIDTH-1:0] in_data, // offered word
    output logic out_valid, // head word present
    input wire logic out_ready, // drain side takes head
    output logic [WIDTH-1:0] out_data, // head word
    output logic [DEPTH-1:0][WIDTH-1:0] view, // contents, oldest first
    output logic [DEPTH-1:0] view_valid // which view slots hold data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [PW:0] count;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t nxt;
    logic push;
    logic pop;

    assign in_ready = st.count < (PW+1)'(DEPTH);
    assign out_valid = st.count != '0;
    assign out_data = st.mem[st.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_view
            assign view[g] = st.mem[PW'(st.rd + PW'(g))];
            assign view_valid[g] = (PW+1)'(g) < st.count;
        end
    endgenerate

    always_comb begin
        nxt = st;
        if (push) begin
            nxt.mem[st.wr] = in_data;
            nxt.wr = st.wr + PW'(1);
        end
        if (pop) begin
            nxt.rd = st.rd + PW'(1);
        end
        if (push && !pop) begin
            nxt.count = st.count + (PW+1)'(1);
        end else if (pop && !push) begin
            nxt.count = st.count - (PW+1)'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end
endmodule
`default_nettype wire

// ---- hw/no_turnaround_sync_sram.sv ----
/*
 * pipelined synchronous sram with no bus turnaround: reads return two
 * edges after their address, write data is taken two edges after its
 * address, so any mix of reads and writes runs back to back.
 * assumes the bus master runs on core_clk; the strap and sleep pins are
 * asynchronous and are synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none
module no_turnaround_sync_sram
    import sram_pkg::*;
(
    input wire logic core_clk, // 25 MHz clock
    input wire logic reset, // synchronous, active high
    input wire logic [ADDR_W-1:0] addr, // address, bit 0/1 feed burst
    input wire logic chip_sel_n, // low selects device on load
    input wire logic write_n, // low writes, high reads
    input wire logic advance_load_ctl, // high advances, low loads
    input wire logic clk_en_n, // low lets the edge act
    input wire logic [LANES-1:0] byte_en_n, // low enables a byte lane
    input wire logic out_en_n, // low allows read data onto bus
    input wire logic [DATA_W-1:0] dq_in, // data bus level in
    output logic [DATA_W-1:0] dq_out, // data bus drive value
    output logic dq_oe, // high while driving data bus
    input wire logic burst_order_select_n, // strap: low linear
    input wire logic sleep_request, // high asks for snooze
    output logic snooze_active, // high while snoozing
    output logic write_buf_ready // low when write buffer full
);

    typedef struct packed {
        logic [1:0] sleep_sync;
        logic [1:0] order_sync;
        stage_t s1;
        stage_t s2;
        burst_t bst;
        logic [DATA_W-1:0] dout;
        logic dq_oe;
        logic snooze;
        logic buf_ready;
        logic [MEM_WORDS-1:0][DATA_W-1:0] mem;
    } state_t;

    state_t st;
    state_t nxt;

    logic ce;
    logic asleep;
    logic interleave;
    logic load;
    acc_t kind_now;
    logic [LANES-1:0] be_now;
    logic [ADDR_W-1:0] acc_addr;
    logic [BURST_W-1:0] cnt_next;
    logic [BURST_W-1:0] cont_low;
    logic push_valid;
    logic push_ready;
    logic drain_valid;
    logic drain_ready;
    logic [WR_ENTRY_W-1:0] drain_raw;
    wr_entry_t drain_ent;
    wr_entry_t push_ent;
    logic [WBUF_DEPTH-1:0][WR_ENTRY_W-1:0] wbuf_view;
    logic [WBUF_DEPTH-1:0] wbuf_view_valid;

    function automatic logic [DATA_W-1:0] merge_lanes(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] new_w,
        input logic [LANES-1:0] be
    );
        logic [DATA_W-1:0] w;
        w = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (be[i]) begin
                w[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
            end
        end
        return w;
    endfunction

    // writes still queued must be seen by a read; newest wins
    function automatic logic [DATA_W-1:0] forward_read(
        input logic [DATA_W-1:0] arr_w,
        input logic [ADDR_W-1:0] a,
        input logic [WBUF_DEPTH-1:0][WR_ENTRY_W-1:0] v,
        input logic [WBUF_DEPTH-1:0] vv
    );
        logic [DATA_W-1:0] w;
        wr_entry_t e;
        w = arr_w;
        for (int i = 0; i < WBUF_DEPTH; i++) begin
            e = wr_entry_t'(v[i]);
            if (vv[i] && e.addr == a) begin
                w = merge_lanes(w, e.data, e.be);
            end
        end
        return w;
    endfunction

    assign ce = !clk_en_n;
    assign asleep = st.sleep_sync[1];
    assign interleave = st.order_sync[1];
    assign load = !advance_load_ctl;
    assign cnt_next = st.bst.cnt + BURST_STEP;

    burst_addr_gen u_burst (
        .start_low(st.bst.base[BURST_W-1:0]),
        .beat_cnt(cnt_next),
        .interleave(interleave),
        .beat_low(cont_low)
    );

    always_comb begin
        be_now = ~byte_en_n;
        if (load) begin
            if (chip_sel_n) begin
                kind_now = ACC_NONE;
            end else if (write_n) begin
                kind_now = ACC_READ;
            end else begin
                kind_now = ACC_WRITE;
            end
            acc_addr = addr;
        end else begin
            kind_now = st.bst.kind;
            acc_addr = {st.bst.base[ADDR_W-1:BURST_W], cont_low};
        end
    end

    assign push_valid = ce && st.s2.op == ACC_WRITE;
    assign push_ent = '{addr: st.s2.addr, data: dq_in, be: st.s2.be};
    // the array sleeps in snooze; buffered writes wait, which back-pressures
    assign drain_ready = ce && !asleep;
    assign drain_ent = wr_entry_t'(drain_raw);

    word_fifo #(
        .WIDTH(WR_ENTRY_W),
        .DEPTH(WBUF_DEPTH)
    ) u_wbuf (
        .core_clk(core_clk),
        .reset(reset),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_ent),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_raw),
        .view(wbuf_view),
        .view_valid(wbuf_view_valid)
    );

    always_comb begin
        nxt = st;
        nxt.sleep_sync = {st.sleep_sync[0], sleep_request};
        nxt.order_sync = {st.order_sync[0], burst_order_select_n};
        nxt.buf_ready = push_ready;
        nxt.snooze = asleep;
        if (ce) begin
            if (asleep) begin
                nxt.s1 = '{op: ACC_NONE, addr: st.s1.addr, be: '0};
            end else begin
                if (load) begin
                    nxt.bst = '{kind: kind_now, base: addr, cnt: '0};
                end else begin
                    nxt.bst.cnt = cnt_next;
                end
                nxt.s1.addr = acc_addr;
                nxt.s1.be = be_now;
                if (kind_now == ACC_WRITE && be_now == '0) begin
                    nxt.s1.op = ACC_NONE;
                end else begin
                    nxt.s1.op = kind_now;
                end
            end
            nxt.s2 = st.s1;
            if (st.s2.op == ACC_READ) begin
                nxt.dout = forward_read(st.mem[st.s2.addr], st.s2.addr,
                                        wbuf_view, wbuf_view_valid);
                nxt.dq_oe = !out_en_n;
            end else begin
                nxt.dq_oe = 1'b0;
            end
            if (drain_valid && drain_ready) begin
                nxt.mem[drain_ent.addr] = merge_lanes(
                    st.mem[drain_ent.addr], drain_ent.data, drain_ent.be);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st <= '0;
            st.sleep_sync <= SYNC_RESET;
            st.order_sync <= SYNC_RESET;
        end else begin
            st <= nxt;
        end
    end

    assign dq_out = st.dout;
    assign dq_oe = st.dq_oe;
    assign snooze_active = st.snooze;
    assign write_buf_ready = st.buf_ready;

    // checks on the device's own behaviour
    logic issue_read;
    logic issue_write;
    logic issue_abort;
    logic issue_desel;
    assign issue_read = ce && !asleep && kind_now == ACC_READ;
    assign issue_write = ce && !asleep && kind_now == ACC_WRITE
                         && be_now != '0;
    assign issue_abort = ce && !asleep && kind_now == ACC_WRITE
                         && be_now == '0;
    assign issue_desel = ce && !asleep && kind_now == ACC_NONE;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    a_read_latency:
    assert property (issue_read ##1 ce ##1 (ce && !out_en_n)
                     |=> dq_oe)
        else $error("read data not driven two edges after address");

    a_read_value:
    assert property (issue_read ##1 ce ##1 ce
                     |=> dq_out == forward_read($past(st.mem[st.s2.addr]),
                         $past(st.s2.addr), $past(wbuf_view),
                         $past(wbuf_view_valid)))
        else $error("read data does not match stored word");

    a_write_capture:
    assert property (issue_write ##1 ce ##1 ce |-> push_valid
                     && push_ent.addr == $past(acc_addr, 2))
        else $error("write data not taken two edges after address");

    // the address edge only parks the write; its data comes at stage two
    a_no_same_edge:
    assert property (issue_write |=> st.s1.op == ACC_WRITE
                     && st.s1.addr == $past(acc_addr))
        else $error("write did not wait in stage one after its address");

    a_back_to_back:
    assert property (issue_read ##1 issue_write ##1 (ce && !out_en_n)
                     |=> dq_oe && (!ce || push_valid))
        else $error("read followed by write lost a cycle");

    a_linear_step:
    assert property (ce && !asleep && !load && !interleave
                     |=> st.s1.addr[1:0] == $past(st.s1.addr[1:0]) + 2'h1)
        else $error("linear burst did not increment");

    a_interleave_step:
    assert property (ce && !asleep && !load && interleave
                     |=> (st.s1.addr[1:0] ^ st.bst.base[1:0])
                         == $past(st.bst.cnt) + 2'h1)
        else $error("interleaved burst used wrong flip pattern");

    a_abort_nochange:
    assert property (issue_abort ##1 ce ##1 ce |-> !push_valid)
        else $error("aborted write reached the buffer");

    a_deselect_release:
    assert property (issue_desel ##1 ce ##1 ce |=> !dq_oe)
        else $error("bus driven after deselect");

    a_stall_hold:
    assert property (!ce |=> $stable(dq_out) && $stable(dq_oe)
                     && $stable(st.s1) && $stable(st.s2) && $stable(st.mem))
        else $error("state moved during a stalled edge");

    a_snooze_ignore:
    assert property (asleep && ce |=> st.s1.op == ACC_NONE
                     && $stable(st.mem))
        else $error("bus operation acted on while snoozing");

    // decode and counter checks look one edge on, at what the edge loaded
    a_strap_linear:
    assert property (!burst_order_select_n ##1 !burst_order_select_n
                     |=> !interleave)
        else $error("strap low did not give linear order");

    a_strap_interleave:
    assert property (burst_order_select_n ##1 burst_order_select_n
                     |=> interleave)
        else $error("strap high did not give interleaved order");

    a_decode_read:
    assert property (ce && !asleep && load && !chip_sel_n && write_n
                     |=> st.s1.op == ACC_READ)
        else $error("selected read load did not issue a read");

    a_load_base:
    assert property (ce && !asleep && load
                     |=> st.bst.base == $past(addr) && st.bst.cnt == '0
                         && st.bst.kind == $past(kind_now))
        else $error("load did not restart the burst");

    a_beat_count:
    assert property (ce && !asleep && !load
                     |=> st.bst.cnt == $past(st.bst.cnt) + 2'h1)
        else $error("burst counter did not step by one");

    a_stall_burst:
    assert property (!ce |=> $stable(st.bst))
        else $error("burst state moved during a stalled edge");

    a_abort_idle:
    assert property (issue_abort |=> st.s1.op == ACC_NONE)
        else $error("aborted write entered the pipeline");

    a_desel_idle:
    assert property (issue_desel |=> st.s1.op == ACC_NONE)
        else $error("deselect entered the pipeline");

    c_read_burst: cover property (issue_read && load ##1 (issue_read
                                  && !load) [*3]);
    c_write_then_read: cover property (issue_write ##1 issue_read);
    c_stall_mid: cover property (issue_read ##1 !ce ##1 ce ##1 dq_oe);
    c_buffer_full: cover property (!write_buf_ready);
    c_snooze_write: cover property (asleep && push_valid);

endmodule
`default_nettype wire

// ---- dv/sram_bus_master.sv ----
/*
 * controller model for the sram bus: drives the pins from a per-cycle
 * request and presents write data two enabled edges after its address.
 * assumes requests change just after rising core_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module sram_bus_master
    import sram_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic reset, // synchronous, active high
    input wire logic stall, // high stalls this edge
    input wire logic load, // high loads a new address
    input wire logic sel, // select on load
    input wire logic wr, // write on load
    input wire logic due, // request carries write data
    input wire logic [ADDR_W-1:0] req_addr, // request address
    input wire logic [LANES-1:0] req_be_n, // lane enables
    input wire logic [DATA_W-1:0] req_data, // write data
    output logic [ADDR_W-1:0] addr, // bus address
    output logic chip_sel_n, // bus select
    output logic write_n, // bus write
    output logic advance_load_ctl, // bus advance or load
    output logic clk_en_n, // bus clock enable
    output logic [LANES-1:0] byte_en_n, // bus lane enables
    output logic [DATA_W-1:0] dq_in // bus data toward device
);
    logic [DATA_W:0] pend_q;

    assign addr = req_addr;
    assign chip_sel_n = ~sel;
    assign write_n = ~wr;
    assign clk_en_n = stall;
    assign byte_en_n = req_be_n;
    assign advance_load_ctl = ~load;

    // data two edges late
    // idle cycles invert the bus, so data taken with its address is wrong
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pend_q <= '0;
            dq_in <= '0;
        end else if (!clk_en_n) begin
            pend_q <= {due, req_data};
            dq_in <= pend_q[DATA_W] ? pend_q[DATA_W-1:0] : ~dq_in;
        end
    end
endmodule
`default_nettype wire

// ---- dv/no_turnaround_sync_sram_tb_top.sv ----
/*
 * self-checking bench: random mix of reads, writes, bursts, aborts,
 * deselects and stalls in both burst orders, then snooze.
 * assumes the controller model sram_bus_master on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module no_turnaround_sync_sram_tb_top;
    import sram_pkg::*;

    typedef struct packed {
        logic rd;
        logic [DATA_W-1:0] d;
    } exp_t;

    logic core_clk, reset, stall, load, sel, wr, due, out_en_n;
    logic burst_order_select_n, sleep_request, want_sleep, want_strap;
    logic [ADDR_W-1:0] r_addr, addr;
    logic [LANES-1:0] r_be_n, byte_en_n;
    logic [DATA_W-1:0] r_data, dq_in, dq_out;
    logic chip_sel_n, write_n, advance_load_ctl, clk_en_n;
    logic dq_oe, snooze_active, write_buf_ready;
    logic [DATA_W-1:0] ref_mem [MEM_WORDS];
    exp_t p0, p1, p2, cur;
    logic cur_oen, oen_s;
    logic [1:0] kind, cnt;
    logic [ADDR_W-1:0] base;
    logic [31:0] r;
    integer err_count, n_tests, seed;

    sram_bus_master sram_bus_master_i (.core_clk(core_clk), .reset(reset),
        .stall(stall), .load(load), .sel(sel), .wr(wr), .due(due),
        .req_addr(r_addr), .req_be_n(r_be_n), .req_data(r_data),
        .addr(addr), .chip_sel_n(chip_sel_n), .write_n(write_n),
        .advance_load_ctl(advance_load_ctl), .clk_en_n(clk_en_n),
        .byte_en_n(byte_en_n), .dq_in(dq_in));

    no_turnaround_sync_sram no_turnaround_sync_sram_i (.core_clk(core_clk),
        .reset(reset), .addr(addr), .chip_sel_n(chip_sel_n),
        .write_n(write_n), .advance_load_ctl(advance_load_ctl),
        .clk_en_n(clk_en_n), .byte_en_n(byte_en_n), .out_en_n(out_en_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .burst_order_select_n(burst_order_select_n),
        .sleep_request(sleep_request), .snooze_active(snooze_active),
        .write_buf_ready(write_buf_ready));

    function automatic logic [1:0] beat(input logic [1:0] s,
        input logic [1:0] n, input logic il);
        return il ? (s ^ n) : (s + n);
    endfunction

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
        input logic [DATA_W-1:0] n, input logic [LANES-1:0] ben);
        logic [DATA_W-1:0] m;
        m = o;
        for (int i = 0; i < LANES; i++)
            if (!ben[i]) m[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
        return m;
    endfunction

    task automatic chk(input string what, input logic [DATA_W-1:0] seen,
        input logic [DATA_W-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one bus cycle: request driven after the edge, outputs checked mid-cycle
    task automatic cyc(input logic st, input logic ld, input logic s,
        input logic w, input logic [ADDR_W-1:0] a,
        input logic [LANES-1:0] ben, input logic [DATA_W-1:0] d,
        input logic oen, input logic snz);
        logic [ADDR_W-1:0] eff;
        logic go;
        @(posedge core_clk);
        if (!stall) begin
            p2 = p1;
            p1 = p0;
            p0 = cur;
            oen_s = cur_oen;
        end
        go = 1'h0;
        eff = a;
        if (!st && !snz) begin
            // ld and w are pin levels: advance/load and write_n
            if (!ld) begin
                kind = !s ? 2'h0 : (w ? 2'h1 : 2'h2);
                base = a;
                cnt = 2'h0;
            end else
                cnt = cnt + 2'h1;
            eff = {base[ADDR_W-1:2], beat(base[1:0], cnt,
                burst_order_select_n)};
            go = (kind != 2'h0);
        end
        cur.rd = go && kind == 2'h1;
        cur.d = ref_mem[eff];
        cur_oen = oen;
        if (go && kind == 2'h2) ref_mem[eff] = merge(ref_mem[eff], d, ben);
        stall <= st;
        load <= !ld;
        sel <= s;
        wr <= !w;
        due <= go && kind == 2'h2;
        r_addr <= a;
        r_be_n <= ben;
        r_data <= d;
        out_en_n <= oen;
        sleep_request <= want_sleep;
        burst_order_select_n <= want_strap;
        @(negedge core_clk);
        chk("dq_oe", dq_oe, p2.rd && !oen_s);
        if (p2.rd && !oen_s) chk("dq_out", dq_out, p2.d);
    endtask

    task automatic idle();
        cyc(1'h0, 1'h0, 1'h0, 1'h0, '0, '1, '0, 1'h0, 1'h0);
    endtask

    task automatic wait_snooze(input logic v);
        for (int k = 0; k < 10 && snooze_active !== v; k++)
            idle();
        chk("snooze_active", snooze_active, v);
        if (snooze_active !== v) end_sim();
    endtask

    initial begin
        core_clk = 1'h0;
        forever #20 core_clk = ~core_clk;
    end

    initial begin
        reset = 1'h1;
        {stall, load, sel, wr, due, out_en_n} = '0;
        {burst_order_select_n, sleep_request, want_sleep, want_strap} = '0;
        r_addr = '0;
        r_be_n = '1;
        r_data = '0;
        {p0, p1, p2, cur, cur_oen, oen_s, kind, cnt, base} = '0;
        err_count = 0;
        n_tests = 0;
        seed = 49222;
        for (int i = 0; i < MEM_WORDS; i++) ref_mem[i] = '0;
        repeat (6) @(posedge core_clk);
        reset <= 1'h0;
        for (int m = 0; m < 2; m++) begin
            // strap settles through the synchroniser while idle
            want_strap = m[0];
            repeat (4) idle();
            // write then read of the same word, no gap
            cyc(1'h0, 1'h0, 1'h1, 1'h0, 6'h09, 4'h0, 32'hA5A51234, 1'h0,
                1'h0);
            cyc(1'h0, 1'h0, 1'h1, 1'h1, 6'h09, 4'h0, '0, 1'h0, 1'h0);
            // four-beat write burst, read from mid
            cyc(1'h0, 1'h0, 1'h1, 1'h0, 6'h10, 4'h0, 32'h11110000, 1'h0,
                1'h0);
            for (int b = 1; b < 4; b++)
                cyc(1'h0, 1'h1, 1'h0, 1'h0, '0, 4'h0, 32'h1111 * b,
                    1'h0, 1'h0);
            cyc(1'h0, 1'h0, 1'h1, 1'h1, 6'h12, 4'h0, '0, 1'h0, 1'h0);
            for (int b = 1; b < 6; b++)
                cyc(1'h0, 1'h1, 1'h0, 1'h0, '0, 4'h0, '0, 1'h0, 1'h0);
            for (int i = 0; i < 400; i++) begin
                r = $random(seed);
                cyc(r[2:0] == 3'h0, r[3], r[4] | r[5], r[6], r[12:7],
                    r[15:13] == 3'h0 ? 4'hF : r[19:16], $random(seed),
                    r[22:20] == 3'h0, 1'h0);
                chk("write_buf_ready", write_buf_ready, 1'h1);
            end
        end
        // requests during snooze leave memory alone
        want_sleep = 1'h1;
        wait_snooze(1'h1);
        cyc(1'h0, 1'h0, 1'h1, 1'h0, 6'h10, 4'h0, 32'h0BADF00D, 1'h0, 1'h1);
        cyc(1'h0, 1'h0, 1'h1, 1'h1, 6'h10, 4'h0, '0, 1'h0, 1'h1);
        repeat (3) cyc(1'h0, 1'h0, 1'h0, 1'h0, '0, '1, '0, 1'h0, 1'h1);
        want_sleep = 1'h0;
        wait_snooze(1'h0);
        cyc(1'h0, 1'h0, 1'h1, 1'h1, 6'h10, 4'h0, '0, 1'h0, 1'h0);
        repeat (4) idle();
        end_sim();
    end
endmodule
`default_nettype wire
